// ---- hw/dzvg_regs.sv ----
`timescale 1ns/1ps
// How it works
// (RULE1) zero flag: mute/data sources, enable and polarity
// (RULE2) first pin: left zero flag or interrupt
// (RULE3) second pin field used only in interrupt mode
// (RULE4) second pin: right, left, either, both zero
// (RULE5) left volume: 0.375 dB steps from 0xFF
// (RULE6) right volume: own register, same encoding
// (RULE7) left peak: 6-bit code, 1 dB steps
// (RULE8) right peak: own register, same encoding
// (RULE9) left record gain: 0.5 dB steps, 24 dB cap
// (RULE10) right record gain: own register, same cap
// (RULE11) reserved bits read zero, writes ignored
// (RULE12) peak readouts updated once per window of samples
module dzvg_regs #(
   parameter int SAMPLE_W = 24,
   parameter int PEAK_WINDOW = dzvg_pkg::PEAK_WINDOW_SAMPLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port behind the serial control port
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // playback sample stream in
   input wire logic play_sample_valid,
   input wire logic signed [SAMPLE_W-1:0] play_left_sample,
   input wire logic signed [SAMPLE_W-1:0] play_right_sample,
   // mute controls and interrupt source from the rest of the device
   input wire logic play_left_mute,
   input wire logic play_right_mute,
   input wire logic irq_request,
   // scaled playback stream out
   output logic play_out_valid,
   output logic signed [SAMPLE_W-1:0] play_left_out,
   output logic signed [SAMPLE_W-1:0] play_right_out,
   // flag pins
   output logic left_flag_or_irq_pin,
   output logic right_flag_pin,
   // record gain to the input amplifiers
   output logic [5:0] record_left_pga_gain,
   output logic [5:0] record_right_pga_gain
);
   // magnitude drops the sign bit; the product holds a sample times a 17-bit mantissa
   // window counter is wide enough to hold the window length itself
   localparam int MAG_W = SAMPLE_W - 1;
   localparam int MUL_W = SAMPLE_W + 17;
   localparam int WIN_W = $clog2(PEAK_WINDOW + 1);

   logic zero_flag_on_mute_disable_ff;
   logic zero_flag_on_data_disable_ff;
   logic zero_flag_polarity_ff;
   logic first_pin_irq_select_ff;
   logic [1:0] second_pin_function_ff;
   logic [7:0] play_left_volume_code_ff;
   logic [7:0] play_right_volume_code_ff;
   logic [5:0] play_left_peak_code_ff;
   logic [5:0] play_right_peak_code_ff;
   logic [5:0] record_left_gain_code_ff;
   logic [5:0] record_right_gain_code_ff;
   logic left_data_zero_ff;
   logic right_data_zero_ff;
   logic [MAG_W-1:0] left_max_ff;
   logic [MAG_W-1:0] right_max_ff;
   logic [WIN_W-1:0] win_cnt_ff;
   logic left_zero;
   logic right_zero;
   logic left_flag;
   logic right_flag;
   logic nxt_right_pin;
   logic [MAG_W-1:0] left_mag;
   logic [MAG_W-1:0] right_mag;
   logic win_end;

   // magnitude of a signed sample, full negative saturates
   function automatic logic [MAG_W-1:0] mag_of(input logic signed [SAMPLE_W-1:0] s);
      logic [SAMPLE_W-1:0] neg;
      neg = SAMPLE_W'(-s);
      if (!s[SAMPLE_W-1]) begin
         mag_of = s[MAG_W-1:0];
      end else if (neg[SAMPLE_W-1]) begin
         mag_of = {MAG_W{1'b1}};
      end else begin
         mag_of = neg[MAG_W-1:0];
      end
   endfunction : mag_of

   // volume scale: shift by whole 6 dB steps, mantissa for the rest
   function automatic logic signed [SAMPLE_W-1:0] vol_scale(input logic signed [SAMPLE_W-1:0] s,
                                                             input logic [7:0] code);
      logic [7:0] atten;
      logic signed [MUL_W-1:0] prod;
      atten = dzvg_pkg::VOL_FULL_SCALE - code;
      prod = MUL_W'(s) * $signed({1'b0, dzvg_pkg::VOL_MANTISSA[atten[3:0]]});
      prod = prod >>> dzvg_pkg::VOL_MANT_FRAC;
      prod = prod >>> atten[7:4];
      vol_scale = prod[SAMPLE_W-1:0];
   endfunction : vol_scale

   // peak code: 6 dB per leading zero plus 1 dB fine steps
   function automatic logic [5:0] peak_code(input logic [MAG_W-1:0] mag);
      int lz;
      int fine;
      int total;
      logic [MAG_W-1:0] norm;
      logic [7:0] top;
      lz = MAG_W;
      for (int i = 0; i < MAG_W; i++) begin
         if (mag[i]) begin
            lz = MAG_W - 1 - i;
         end
      end
      norm = mag << lz;
      top = norm[MAG_W-1 -: 8];
      fine = 5;
      for (int k = 4; k >= 0; k--) begin
         if (top >= dzvg_pkg::PEAK_THRESH[k]) begin
            fine = k;
         end
      end
      total = dzvg_pkg::PEAK_DB_PER_OCTAVE * lz + fine;
      if (mag == '0 || total > int'(dzvg_pkg::PEAK_MIN_CODE)) begin
         peak_code = dzvg_pkg::PEAK_MIN_CODE;
      end else begin
         peak_code = 6'(total);
      end
   endfunction : peak_code

   // record gain saturation
   function automatic logic [5:0] gain_sat(input logic [5:0] code);
      gain_sat = (code > dzvg_pkg::GAIN_MAX_CODE) ? dzvg_pkg::GAIN_MAX_CODE : code;
   endfunction : gain_sat

   // register writes, reserved bits dropped
   // only the defined field bits are stored, so reserved bits cost no flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         zero_flag_on_mute_disable_ff <= dzvg_pkg::RST_ZERO_FLAG_CONFIG[dzvg_pkg::BIT_ZERO_FLAG_ON_MUTE_DISABLE];
         zero_flag_on_data_disable_ff <= dzvg_pkg::RST_ZERO_FLAG_CONFIG[dzvg_pkg::BIT_ZERO_FLAG_ON_DATA_DISABLE];
         zero_flag_polarity_ff <= dzvg_pkg::RST_ZERO_FLAG_CONFIG[dzvg_pkg::BIT_ZERO_FLAG_POLARITY];
         first_pin_irq_select_ff <= dzvg_pkg::RST_FLAG_PIN_FUNCTION[2];
         second_pin_function_ff <= dzvg_pkg::RST_FLAG_PIN_FUNCTION[1:0];
         play_left_volume_code_ff <= dzvg_pkg::RST_VOLUME;
         play_right_volume_code_ff <= dzvg_pkg::RST_VOLUME;
         record_left_gain_code_ff <= dzvg_pkg::RST_GAIN;
         record_right_gain_code_ff <= dzvg_pkg::RST_GAIN;
      end else if (reg_wr) begin
         if (reg_addr == dzvg_pkg::ADDR_ZERO_FLAG_CONFIG) begin // see (RULE11)
            zero_flag_on_mute_disable_ff <= reg_wdata[dzvg_pkg::BIT_ZERO_FLAG_ON_MUTE_DISABLE];
            zero_flag_on_data_disable_ff <= reg_wdata[dzvg_pkg::BIT_ZERO_FLAG_ON_DATA_DISABLE];
            zero_flag_polarity_ff <= reg_wdata[dzvg_pkg::BIT_ZERO_FLAG_POLARITY];
         end else if (reg_addr == dzvg_pkg::ADDR_FLAG_PIN_FUNCTION) begin
            first_pin_irq_select_ff <= reg_wdata[dzvg_pkg::BIT_FIRST_PIN_IRQ_SELECT];
            second_pin_function_ff <= reg_wdata[dzvg_pkg::BIT_SECOND_PIN_FUNCTION_LO +: 2];
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_LEFT_VOLUME) begin
            play_left_volume_code_ff <= reg_wdata;
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_RIGHT_VOLUME) begin
            play_right_volume_code_ff <= reg_wdata; // see (RULE6)
         end else if (reg_addr == dzvg_pkg::ADDR_RECORD_LEFT_GAIN) begin
            record_left_gain_code_ff <= reg_wdata[5:0];
         end else if (reg_addr == dzvg_pkg::ADDR_RECORD_RIGHT_GAIN) begin
            record_right_gain_code_ff <= reg_wdata[5:0];
         end
      end
   end

   // register reads, unmapped and reserved bits as zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == dzvg_pkg::ADDR_ZERO_FLAG_CONFIG) begin
            reg_rdata <= {5'h00, zero_flag_on_mute_disable_ff, zero_flag_on_data_disable_ff,
                          zero_flag_polarity_ff}; // see (RULE11)
         end else if (reg_addr == dzvg_pkg::ADDR_FLAG_PIN_FUNCTION) begin
            reg_rdata <= {1'b0, first_pin_irq_select_ff, second_pin_function_ff, 4'h0};
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_LEFT_VOLUME) begin
            reg_rdata <= play_left_volume_code_ff;
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_RIGHT_VOLUME) begin
            reg_rdata <= play_right_volume_code_ff;
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_LEFT_PEAK) begin
            reg_rdata <= {2'h0, play_left_peak_code_ff}; // see (RULE7)
         end else if (reg_addr == dzvg_pkg::ADDR_PLAY_RIGHT_PEAK) begin
            reg_rdata <= {2'h0, play_right_peak_code_ff}; // see (RULE8)
         end else if (reg_addr == dzvg_pkg::ADDR_RECORD_LEFT_GAIN) begin
            reg_rdata <= {2'h0, record_left_gain_code_ff};
         end else if (reg_addr == dzvg_pkg::ADDR_RECORD_RIGHT_GAIN) begin
            reg_rdata <= {2'h0, record_right_gain_code_ff};
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // volume scaling of the playback stream
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         play_out_valid <= 1'b0;
         play_left_out <= '0;
         play_right_out <= '0;
      end else begin
         play_out_valid <= play_sample_valid;
         if (play_sample_valid) begin
            play_left_out <= vol_scale(play_left_sample, play_left_volume_code_ff); // see (RULE5)
            play_right_out <= vol_scale(play_right_sample, play_right_volume_code_ff); // see (RULE6)
         end
      end
   end

   // zero data detection per accepted sample
   // no run-length filter: one zero sample between loud ones raises the flag
   // for one sample period, which a host polling the pins may never see
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         left_data_zero_ff <= 1'b0;
         right_data_zero_ff <= 1'b0;
      end else if (play_sample_valid) begin
         left_data_zero_ff <= (play_left_sample == '0);
         right_data_zero_ff <= (play_right_sample == '0);
      end
   end

   // per channel zero condition and pin polarity
   assign left_zero = (!zero_flag_on_mute_disable_ff && (play_left_mute || play_left_volume_code_ff == 8'h00))
                      || (!zero_flag_on_data_disable_ff && left_data_zero_ff); // see (RULE1)
   assign right_zero = (!zero_flag_on_mute_disable_ff && (play_right_mute || play_right_volume_code_ff == 8'h00))
                       || (!zero_flag_on_data_disable_ff && right_data_zero_ff); // see (RULE1)

   // second pin function select
   always_comb begin
      nxt_right_pin = right_zero;
      if (first_pin_irq_select_ff) begin // see (RULE3)
         case (second_pin_function_ff) // see (RULE4)
            dzvg_pkg::SEL_RIGHT_ZERO: nxt_right_pin = right_zero;
            dzvg_pkg::SEL_LEFT_ZERO: nxt_right_pin = left_zero;
            dzvg_pkg::SEL_EITHER_ZERO: nxt_right_pin = left_zero || right_zero;
            default: nxt_right_pin = left_zero && right_zero;
         endcase
      end
   end

   assign left_flag = left_zero ^ zero_flag_polarity_ff; // see (RULE1)
   assign right_flag = nxt_right_pin ^ zero_flag_polarity_ff;

   // registered flag pins
   // registering hides the select glitches of the mux from the pins
   // interrupt mode passes the request raw, without the flag polarity
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         left_flag_or_irq_pin <= 1'b0;
         right_flag_pin <= 1'b0;
      end else begin
         left_flag_or_irq_pin <= first_pin_irq_select_ff ? irq_request : left_flag; // see (RULE2)
         right_flag_pin <= right_flag;
      end
   end

   // peak tracking over a window of samples
   // the sample that closes a window still counts toward its maximum;
   // the readout holds the previous window's code until the next one closes
   assign left_mag = mag_of(play_left_sample);
   assign right_mag = mag_of(play_right_sample);
   assign win_end = play_sample_valid && (win_cnt_ff == WIN_W'(PEAK_WINDOW - 1));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         win_cnt_ff <= '0;
         left_max_ff <= '0;
         right_max_ff <= '0;
         play_left_peak_code_ff <= dzvg_pkg::RST_PEAK;
         play_right_peak_code_ff <= dzvg_pkg::RST_PEAK;
      end else if (win_end) begin
         win_cnt_ff <= '0;
         left_max_ff <= '0;
         right_max_ff <= '0;
         play_left_peak_code_ff <= peak_code((left_mag > left_max_ff) ? left_mag : left_max_ff); // see (RULE12)
         play_right_peak_code_ff <= peak_code((right_mag > right_max_ff) ? right_mag : right_max_ff); // see (RULE12)
      end else if (play_sample_valid) begin
         win_cnt_ff <= win_cnt_ff + WIN_W'(1);
         if (left_mag > left_max_ff) begin
            left_max_ff <= left_mag;
         end
         if (right_mag > right_max_ff) begin
            right_max_ff <= right_mag;
         end
      end
   end

   // record gain to the amplifiers, saturated
   // codes above the cap are stored and read back raw; only the amplifier sees the cap
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         record_left_pga_gain <= dzvg_pkg::RST_GAIN;
         record_right_pga_gain <= dzvg_pkg::RST_GAIN;
      end else begin
         record_left_pga_gain <= gain_sat(record_left_gain_code_ff); // see (RULE9)
         record_right_pga_gain <= gain_sat(record_right_gain_code_ff); // see (RULE10)
      end
   end
endmodule : dzvg_regs

// ---- include/dzvg_pkg.sv ----
package dzvg_pkg;
   // register offsets on the serial control port
   localparam logic [6:0] ADDR_ZERO_FLAG_CONFIG = 7'h66;
   localparam logic [6:0] ADDR_FLAG_PIN_FUNCTION = 7'h67;
   localparam logic [6:0] ADDR_PLAY_LEFT_VOLUME = 7'h68;
   localparam logic [6:0] ADDR_PLAY_RIGHT_VOLUME = 7'h69;
   localparam logic [6:0] ADDR_PLAY_LEFT_PEAK = 7'h6A;
   localparam logic [6:0] ADDR_PLAY_RIGHT_PEAK = 7'h6B;
   localparam logic [6:0] ADDR_RECORD_LEFT_GAIN = 7'h6C;
   localparam logic [6:0] ADDR_RECORD_RIGHT_GAIN = 7'h6D;

   // field positions in zero_flag_config
   localparam int BIT_ZERO_FLAG_ON_MUTE_DISABLE = 2;
   localparam int BIT_ZERO_FLAG_ON_DATA_DISABLE = 1;
   localparam int BIT_ZERO_FLAG_POLARITY = 0;
   // field positions in flag_pin_function
   localparam int BIT_FIRST_PIN_IRQ_SELECT = 6;
   localparam int BIT_SECOND_PIN_FUNCTION_LO = 4;

   // second pin function codes
   localparam logic [1:0] SEL_RIGHT_ZERO = 2'h0;
   localparam logic [1:0] SEL_LEFT_ZERO = 2'h1;
   localparam logic [1:0] SEL_EITHER_ZERO = 2'h2;
   localparam logic [1:0] SEL_BOTH_ZERO = 2'h3;

   // reset values
   localparam logic [2:0] RST_ZERO_FLAG_CONFIG = 3'h0;
   localparam logic [2:0] RST_FLAG_PIN_FUNCTION = 3'h0;
   localparam logic [7:0] RST_VOLUME = 8'hFF;
   localparam logic [5:0] RST_GAIN = 6'h00;
   localparam logic [5:0] RST_PEAK = 6'h3F;

   // volume: 16 steps of 0.375 dB make 6 dB, i.e. one halving
   localparam logic [7:0] VOL_FULL_SCALE = 8'hFF;
   localparam logic [16:0] VOL_MANTISSA [16] = '{
      17'h08000, 17'h07A93, 17'h07560, 17'h07066, 17'h06BA2, 17'h06712, 17'h062B4, 17'h05E84,
      17'h05A82, 17'h056AC, 17'h052FF, 17'h04F7B, 17'h04C1C, 17'h048E2, 17'h045CB, 17'h042D5};
   localparam int VOL_MANT_FRAC = 15;

   // record gain saturates at 24 dB
   localparam logic [5:0] GAIN_MAX_CODE = 6'h30;

   // peak: 1 dB steps; thresholds of the top 8 bits within one octave
   localparam logic [7:0] PEAK_THRESH [5] = '{8'hE4, 8'hCB, 8'hB5, 8'hA1, 8'h90};
   localparam logic [5:0] PEAK_MIN_CODE = 6'h3F;
   localparam int PEAK_DB_PER_OCTAVE = 6;
   localparam int PEAK_WINDOW_SAMPLES = 1024;
endpackage : dzvg_pkg

// ---- verif/dzvg_regs_chk.sv ----
`timescale 1ns/1ps
module dzvg_regs_chk #(
   parameter int SAMPLE_W = 24
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // stream, pins and gains
   input wire logic play_sample_valid,
   input wire logic irq_request,
   input wire logic play_out_valid,
   input wire logic signed [SAMPLE_W-1:0] play_left_out,
   input wire logic left_flag_or_irq_pin,
   input wire logic [5:0] record_left_pga_gain,
   input wire logic [5:0] record_right_pga_gain
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic irq_mode_ff;
   // shadow of the first pin mode bit
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         irq_mode_ff <= 1'b0;
      else if (reg_wr && reg_addr == dzvg_pkg::ADDR_FLAG_PIN_FUNCTION)
         irq_mode_ff <= reg_wdata[dzvg_pkg::BIT_FIRST_PIN_IRQ_SELECT];
   end
   // write of a left gain code at or above the cap
   sequence s_gain_sat_wr;
      reg_wr && reg_addr == dzvg_pkg::ADDR_RECORD_LEFT_GAIN && reg_wdata[5:0] >= dzvg_pkg::GAIN_MAX_CODE;
   endsequence
   sequence s_peak_rd;
      reg_rd && (reg_addr == dzvg_pkg::ADDR_PLAY_LEFT_PEAK || reg_addr == dzvg_pkg::ADDR_PLAY_RIGHT_PEAK);
   endsequence
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   chk_out_valid: assert property (play_sample_valid |=> play_out_valid)
      else $error("no output strobe after a sample");
   chk_no_extra_out: assert property (play_out_valid |-> $past(play_sample_valid))
      else $error("output strobe without a sample");
   chk_out_held: assert property (!play_sample_valid |=> $stable(play_left_out))
      else $error("output sample moved between strobes");
   chk_gain_cap: assert property (record_left_pga_gain <= 6'h30 && record_right_pga_gain <= 6'h30)
      else $error("gain above cap");
   chk_gain_sat: assert property (s_gain_sat_wr |-> ##[1:2] record_left_pga_gain == 6'h30)
      else $error("gain not saturated");
   chk_irq_pass: assert property (irq_mode_ff |=> left_flag_or_irq_pin == $past(irq_request))
      else $error("first pin not following interrupt");
   chk_unmapped_rd: assert property (reg_rd && (reg_addr < 7'h66 || reg_addr > 7'h6D) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_peak_resvd: assert property (s_peak_rd |=> reg_rdata[7:6] == 2'h0)
      else $error("peak reserved bits set");
   chk_cfg_resvd: assert property (reg_rd && reg_addr == 7'h66 |=> reg_rdata[7:3] == 5'h00)
      else $error("config reserved bits set");
endmodule : dzvg_regs_chk

// ---- verif/dzvg_host.sv ----
`timescale 1ns/1ps
module dzvg_host (
   // clock
   input wire logic clk_sys,
   // register port toward the device
   output logic [6:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   // idle port
   initial begin
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // one write strobe, lines flipped once released
   task automatic write(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : write
   // one read strobe, data taken once registered
   task automatic read(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge clk_sys);
      #1;
      d = reg_rdata;
   endtask : read
endmodule : dzvg_host

// ---- verif/dzvg_regs_test.sv ----
`timescale 1ns/1ps
module dzvg_regs_test;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic play_sample_valid = 1'b0;
   logic signed [23:0] play_left_sample = 24'h000000;
   logic signed [23:0] play_right_sample = 24'h000000;
   logic play_left_mute = 1'b0;
   logic play_right_mute = 1'b0;
   logic irq_request = 1'b0;
   logic [6:0] reg_addr;
   logic reg_wr, reg_rd, play_out_valid, left_flag_or_irq_pin, right_flag_pin;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic signed [23:0] play_left_out, play_right_out;
   logic [5:0] record_left_pga_gain, record_right_pga_gain;
   int n_fail = 0;
   int n_tests = 0;
   // reset values and readback after writing all ones, offsets 0x66 up
   logic [7:0] tab_rst [8] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h00, 8'h00};
   logic [7:0] tab_ones [8] = '{8'h07, 8'h70, 8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
   logic [1:0] sel_exp = 2'h0;
   always #20 clk_sys = ~clk_sys;
   dzvg_regs #(.SAMPLE_W(24), .PEAK_WINDOW(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .play_sample_valid(play_sample_valid), .play_left_sample(play_left_sample),
      .play_right_sample(play_right_sample), .play_left_mute(play_left_mute), .play_right_mute(play_right_mute),
      .irq_request(irq_request), .play_out_valid(play_out_valid), .play_left_out(play_left_out),
      .play_right_out(play_right_out), .left_flag_or_irq_pin(left_flag_or_irq_pin),
      .right_flag_pin(right_flag_pin), .record_left_pga_gain(record_left_pga_gain),
      .record_right_pga_gain(record_right_pga_gain));
   dzvg_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   // compare, report and verdict
   task automatic cmp(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
      host.read(a, rd_val);
      cmp("register", {16'h0000, exp}, {16'h0000, rd_val});
   endtask : rdchk
   // one sample pair, then let flags and pins settle
   task automatic send(input logic [23:0] l, input logic [23:0] r);
      @(posedge clk_sys);
      #1;
      play_sample_valid = 1'b1;
      play_left_sample = l;
      play_right_sample = r;
      @(posedge clk_sys);
      #1;
      play_sample_valid = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : send
   task automatic pins(input logic l, input logic r);
      repeat (3) @(posedge clk_sys);
      #1;
      cmp("left pin", {23'h000000, l}, {23'h000000, left_flag_or_irq_pin});
      cmp("right pin", {23'h000000, r}, {23'h000000, right_flag_pin});
   endtask : pins
   // main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) rdchk(7'h66 + 7'(i), tab_rst[i]);
      for (int i = 0; i < 8; i++) host.write(7'h66 + 7'(i), 8'hFF);
      for (int i = 0; i < 8; i++) rdchk(7'h66 + 7'(i), tab_ones[i]);
      host.write(7'h70, 8'h55);
      rdchk(7'h70, 8'h00);
      host.write(dzvg_pkg::ADDR_PLAY_LEFT_PEAK, 8'h00);
      rdchk(dzvg_pkg::ADDR_PLAY_LEFT_PEAK, 8'h3F);
      host.write(dzvg_pkg::ADDR_RECORD_RIGHT_GAIN, 8'h01);
      pins(1'b0, 1'b1);
      cmp("left gain", 24'h000030, {18'h00000, record_left_pga_gain});
      cmp("right gain", 24'h000001, {18'h00000, record_right_pga_gain});
      host.write(dzvg_pkg::ADDR_ZERO_FLAG_CONFIG, 8'h00);
      host.write(dzvg_pkg::ADDR_FLAG_PIN_FUNCTION, 8'h00);
      host.write(dzvg_pkg::ADDR_PLAY_LEFT_VOLUME, 8'hEF);
      host.write(dzvg_pkg::ADDR_PLAY_RIGHT_VOLUME, 8'hDF);
      send(24'h100000, 24'h100000);
      cmp("left out", 24'h080000, play_left_out);
      cmp("right out", 24'h040000, play_right_out);
      host.write(dzvg_pkg::ADDR_PLAY_LEFT_VOLUME, 8'h00);
      send(24'h400000, 24'h7FFFFF);
      cmp("left out", 24'h000042, play_left_out);
      cmp("right out", 24'h1FFFFF, play_right_out);
      pins(1'b1, 1'b0);
      host.write(dzvg_pkg::ADDR_PLAY_LEFT_VOLUME, 8'hFF);
      send(24'h000000, 24'h000005);
      pins(1'b1, 1'b0);
      play_right_mute = 1'b1;
      pins(1'b1, 1'b1);
      host.write(dzvg_pkg::ADDR_ZERO_FLAG_CONFIG, 8'h05);
      pins(1'b0, 1'b1);
      host.write(dzvg_pkg::ADDR_ZERO_FLAG_CONFIG, 8'h02);
      pins(1'b0, 1'b1);
      host.write(dzvg_pkg::ADDR_ZERO_FLAG_CONFIG, 8'hF8);
      play_right_mute = 1'b0;
      for (int s = 0; s < 4; s++) begin
         irq_request = s[0];
         sel_exp = 2'(s);
         host.write(dzvg_pkg::ADDR_FLAG_PIN_FUNCTION, 8'h40 | {2'h0, sel_exp, 4'h0});
         pins(s[0], s == 1 || s == 2);
      end
      irq_request = 1'b0;
      host.write(dzvg_pkg::ADDR_FLAG_PIN_FUNCTION, 8'h10);
      pins(1'b1, 1'b0);
      rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      for (int w = 0; w < 2; w++) begin
         for (int k = 0; k < 4; k++)
            send(k > 0 ? 24'h0 : (w > 0 ? 24'hC00000 : 24'h7FFFFF), k > 0 ? 24'h0 : (w > 0 ? 24'h7FFFFF : 24'h400000));
         rdchk(dzvg_pkg::ADDR_PLAY_LEFT_PEAK, w > 0 ? 8'h05 : 8'h00);
         rdchk(dzvg_pkg::ADDR_PLAY_RIGHT_PEAK, w > 0 ? 8'h00 : 8'h05);
      end
      summarize();
   end
   // hang guard
   initial begin
      #2000000;
      n_fail++;
      summarize();
   end
endmodule : dzvg_regs_test
bind dzvg_regs dzvg_regs_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .play_sample_valid(play_sample_valid), .irq_request(irq_request), .play_out_valid(play_out_valid),
   .play_left_out(play_left_out), .left_flag_or_irq_pin(left_flag_or_irq_pin),
   .record_left_pga_gain(record_left_pga_gain), .record_right_pga_gain(record_right_pga_gain));
